// >>> sarpr_pkg.sv
// constants for the successive approximation converter readout block
package sarpr_pkg;
	localparam int          SARPR_BITS        = 12;
	localparam int          SARPR_CLK_NS      = 100;
	// conversion time in ns and its cycle count (longest time, rounded down)
	localparam int          SARPR_TCONV_NS    = 2700;
	localparam int          SARPR_CONV_CYC    = (SARPR_TCONV_NS / SARPR_CLK_NS < 1) ? 1 : SARPR_TCONV_NS / SARPR_CLK_NS;
	// acquisition time the host leaves between conversions (least, rounded up)
	localparam int          SARPR_TACQ_NS     = 600;
	localparam int          SARPR_ACQ_CYC     = (SARPR_TACQ_NS + SARPR_CLK_NS - 1) / SARPR_CLK_NS;
	// each bit gets an equal slice of the conversion time
	localparam int          SARPR_BIT_CYC     = SARPR_CONV_CYC / SARPR_BITS;
	localparam logic [4:0]  SARPR_BIT_CYC_M1  = 5'(SARPR_BIT_CYC - 1);
	localparam logic [3:0]  SARPR_MSB_IDX     = 4'hb;
	localparam logic [11:0] SARPR_SAR_RESET   = 12'h000;
	localparam logic [11:0] SARPR_LATCH_RESET = 12'h000;
	// output coding: 0 natural binary (unipolar), 1 two's complement (bipolar)
	localparam logic        SARPR_CODE_UNI    = 1'b0;
	localparam logic        SARPR_CODE_BIP    = 1'b1;

	typedef enum logic [2:0] {
		SARPR_IDLE    = 3'b001,
		SARPR_CONVERT = 3'b010,
		SARPR_LOAD    = 3'b100
	} sarpr_state_type;
endpackage

// >>> sarpr_top.sv
// control and parallel readout of the 12-bit successive approximation converter
// Behaviour
// - upper_byte_select low during read: all twelve result bits on pins, msb on top
// - upper_byte_select high: low nibble pins carry bits 11..8, middle nibble low
// - result is a 12-bit word, bit 11 most significant, bit 0 least
// - start decided from chip select, read strobe and byte select only
// - conversion start clears the approximation register and enables output drivers
// - start conditions during a running conversion are ignored; no restart or abort
// - twelve bits resolved one at a time msb to lsb, decisions kept
// - end of conversion copies approximation register into holding output latches
// - unipolar variant codes plain natural binary, step full scale over 4096
// - bipolar variants code two's complement, bit 11 sign
// - start only when chip select, read and byte select all low together
// - busy output low throughout a conversion, high otherwise
// - data drivers enabled when chip select and read low, else released
// - busy returns high only after latches hold and present the new result
module sarpr_top
	import sarpr_pkg::*;
#(
	parameter logic CODE_MODE = SARPR_CODE_UNI
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        upper_byte_select,
	input  wire logic        comp_high,
	output logic [11:0]      dac_code,
	output logic             busy_n,
	output logic [11:0]      data_out_pins,
	output logic [11:0]      data_out_oe_n
);

	// ==========================================================
	// state
	sarpr_state_type state_reg;
	logic [11:0]     sar_reg;
	logic [11:0]     latch_reg;
	logic [3:0]      bit_idx_reg;
	logic [4:0]      tick_reg;
	logic            start;
	logic            bit_done;
	logic            read_act;
	logic [11:0]     pin_src;

	// result msb inverted for bipolar: offset binary core turned into two's complement
	function automatic logic [11:0] sarpr_code(input logic [11:0] raw, input logic mode);
		sarpr_code = (mode == SARPR_CODE_BIP) ? {~raw[11], raw[10:0]} : raw;
	endfunction

	// ==========================================================
	// start gating
	// all three low
	assign start    = ~cs_n & ~rd_n & ~upper_byte_select;
	assign read_act = ~cs_n & ~rd_n;
	assign bit_done = (tick_reg == SARPR_BIT_CYC_M1);

	// ==========================================================
	// sequencer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_reg <= SARPR_IDLE;
		end else if (clk_en) begin
			case (state_reg)
				// start only looked at in idle
				SARPR_IDLE: begin
					if (start)
						state_reg <= SARPR_CONVERT;
				end
				SARPR_CONVERT: begin
					if (bit_done && bit_idx_reg == 4'h0)
						state_reg <= SARPR_LOAD;
				end
				SARPR_LOAD: begin
					state_reg <= SARPR_IDLE;
				end
				default: begin
					state_reg <= SARPR_IDLE;
				end
			endcase
		end
	end

	// bit timer restarts with the accepted start
	always_ff @(posedge clock) begin
		if (!rstn) begin
			tick_reg    <= 5'h00;
			bit_idx_reg <= SARPR_MSB_IDX;
		end else if (clk_en) begin
			if (state_reg == SARPR_IDLE) begin
				tick_reg    <= 5'h00;
				bit_idx_reg <= SARPR_MSB_IDX;
			end else if (state_reg == SARPR_CONVERT) begin
				tick_reg <= bit_done ? 5'h00 : tick_reg + 5'h01;
				if (bit_done && bit_idx_reg != 4'h0)
					bit_idx_reg <= bit_idx_reg - 4'h1;
			end
		end
	end

	// clear at start, then trial bit msb first, keep decisions
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sar_reg <= SARPR_SAR_RESET;
		end else if (clk_en) begin
			if (state_reg == SARPR_IDLE && start)
				sar_reg <= SARPR_SAR_RESET;
			else if (state_reg == SARPR_CONVERT && bit_done)
				sar_reg[bit_idx_reg] <= comp_high;
		end
	end

	// dac sees the kept decisions plus the bit under trial
	always_comb begin
		dac_code = sar_reg;
		if (state_reg == SARPR_CONVERT)
			dac_code[bit_idx_reg] = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			latch_reg <= SARPR_LATCH_RESET;
		end else if (clk_en && state_reg == SARPR_LOAD) begin
			latch_reg <= sarpr_code(sar_reg, CODE_MODE);
		end
	end

	// ==========================================================
	// pins
	// busy high again only once latch holds result
	assign busy_n = (state_reg == SARPR_IDLE);

	// load cycle feeds pins directly
	// busy rises on the same edge, so the pins must not trail the latch
	assign pin_src = (state_reg == SARPR_LOAD) ? sarpr_code(sar_reg, CODE_MODE) : latch_reg;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			data_out_pins <= 12'h000;
		end else if (clk_en) begin
			if (upper_byte_select)
				data_out_pins <= {pin_src[11:8], 4'h0, pin_src[11:8]};
			else
				data_out_pins <= pin_src;
		end
	end

	// enable low while driving; select changes reach the pins a cycle later
	assign data_out_oe_n = read_act ? 12'h000 : 12'hfff;

	// ==========================================================
	// checks
	chk_no_restart: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && state_reg == SARPR_CONVERT && start) |=>
		state_reg != SARPR_IDLE && (tick_reg != 5'h00 || $past(bit_done)))
		else $error("conversion restarted");
	chk_start_gate: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && state_reg == SARPR_IDLE && upper_byte_select) |=> state_reg == SARPR_IDLE)
		else $error("start with byte select high");
	chk_busy_low: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && state_reg == SARPR_IDLE && start) |=> !busy_n)
		else $error("busy not low after start");
	chk_busy_rise: assert property (@(posedge clock) disable iff (!rstn)
		$rose(busy_n) |-> latch_reg == sarpr_code($past(sar_reg), CODE_MODE) &&
		data_out_pins[11:8] == latch_reg[11:8])
		else $error("busy rose before latch update");
	chk_oe_read: assert property (@(posedge clock) disable iff (!rstn)
		(data_out_oe_n == 12'h000) == (!cs_n && !rd_n))
		else $error("output enable mismatch");
	chk_high_byte: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && upper_byte_select) |=> data_out_pins[7:4] == 4'h0 && data_out_pins[3:0] == data_out_pins[11:8] &&
		data_out_pins[11:8] == latch_reg[11:8])
		else $error("high byte mux wrong");
	chk_full_word: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && !upper_byte_select) |=> data_out_pins == latch_reg)
		else $error("parallel word wrong");
	chk_sar_clear: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && state_reg == SARPR_IDLE && start) |=> sar_reg == SARPR_SAR_RESET)
		else $error("sar not cleared");
	chk_conv_len: assert property (@(posedge clock) disable iff (!rstn)
		(clk_en && state_reg == SARPR_IDLE && start) |=> (!busy_n)[*8])
		else $error("conversion too short");
	chk_conv_end: assert property (@(posedge clock) disable iff (!rstn || !clk_en)
		(clk_en && state_reg == SARPR_IDLE && start) |-> ##25 !busy_n ##1 busy_n)
		else $error("conversion length wrong");

	cov_start:   cover property (@(posedge clock) disable iff (!rstn) state_reg == SARPR_IDLE && start && clk_en);
	cov_done:    cover property (@(posedge clock) disable iff (!rstn) $rose(busy_n));
	cov_hbyte:   cover property (@(posedge clock) disable iff (!rstn) read_act && upper_byte_select);
	cov_ignored: cover property (@(posedge clock) disable iff (!rstn) state_reg == SARPR_CONVERT && start);
endmodule

// >>> sarpr_afe_model.sv
// comparator stand-in for the analog front end behind the converter
module sarpr_afe_model (
	input  wire logic [11:0] dac_code,
	input  wire logic [11:0] vin_code,
	output logic             comp_high
);
	timeunit 1ns;
	timeprecision 1ns;
	// keep trial bit when input not below it
	assign comp_high = (dac_code <= vin_code);
endmodule

// >>> testbench.sv
// self-checking bench for the converter control and readout
module testbench;
	import sarpr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rstn, clk_en, cs_n, rd_n, upper_byte_select, comp_high, busy_n;
	logic comp_high_bip, busy_n_bip;
	logic [11:0] dac_code, data_out_pins, data_out_oe_n, vin;
	logic [11:0] dac_code_bip, data_out_pins_bip, data_out_oe_n_bip;
	int error_cnt, checks_done, cyc;
	sarpr_top i_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n), .rd_n(rd_n),
		.upper_byte_select(upper_byte_select), .comp_high(comp_high), .dac_code(dac_code),
		.busy_n(busy_n), .data_out_pins(data_out_pins), .data_out_oe_n(data_out_oe_n));
	sarpr_afe_model i_afe (.dac_code(dac_code), .vin_code(vin), .comp_high(comp_high));
	// bipolar variant runs in step with the unipolar one on the same host signals
	sarpr_top #(.CODE_MODE(SARPR_CODE_BIP)) i_dut_bip (.clock(clock), .rstn(rstn), .clk_en(clk_en),
		.cs_n(cs_n), .rd_n(rd_n), .upper_byte_select(upper_byte_select), .comp_high(comp_high_bip),
		.dac_code(dac_code_bip), .busy_n(busy_n_bip), .data_out_pins(data_out_pins_bip),
		.data_out_oe_n(data_out_oe_n_bip));
	sarpr_afe_model i_afe_bip (.dac_code(dac_code_bip), .vin_code(vin), .comp_high(comp_high_bip));
	// ==========================================
	// clock, watchdog, checks
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ceiling well above the roughly 150 cycles the tests take
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic step();
		@(posedge clock);
		#10;
	endtask
	// ==========================================
	// scenarios
	task automatic no_select_read();
		cs_n = 1'b1;
		rd_n = 1'b0;
		step();
		check(data_out_oe_n, 12'hfff);
		check({11'h0, busy_n}, 12'h001);
		rd_n = 1'b1;
	endtask
	task automatic frozen_start();
		clk_en = 1'b0;
		cs_n = 1'b0;
		rd_n = 1'b0;
		step();
		step();
		check({11'h0, busy_n}, 12'h001);
		cs_n = 1'b1;
		rd_n = 1'b1;
		clk_en = 1'b1;
		step();
		check({11'h0, busy_n}, 12'h001);
	endtask
	task automatic convert(input logic [11:0] v, input logic [11:0] prev, input bit again);
		int n;
		vin = v;
		repeat (SARPR_ACQ_CYC + 1) step();
		cs_n = 1'b0;
		rd_n = 1'b0;
		#1 check(data_out_oe_n, 12'h000);
		check(data_out_pins, prev);
		step();
		cs_n = 1'b1;
		rd_n = 1'b1;
		check({11'h0, busy_n}, 12'h000);
		n = 0;
		while (busy_n !== 1'b1 && n < 60) begin
			step();
			n++;
			cs_n = !(again && n == 5);
			rd_n = cs_n;
		end
		check(12'(n), 12'(SARPR_BITS * SARPR_BIT_CYC + 1));
		check(data_out_pins, v);
		check(data_out_pins_bip, v - 12'h800);
		step();
	endtask
	task automatic byte_read(input logic [11:0] p);
		upper_byte_select = 1'b1;
		cs_n = 1'b0;
		rd_n = 1'b0;
		step();
		step();
		check(data_out_pins, {p[11:8], 4'h0, p[11:8]});
		check({11'h0, busy_n}, 12'h001);
		cs_n = 1'b1;
		rd_n = 1'b1;
		upper_byte_select = 1'b0;
		step();
		check(data_out_pins, p);
	endtask
	// ==========================================
	// main sequence
	initial begin
		error_cnt = 0;
		checks_done = 0;
		cyc = 0;
		rstn = 1'b0;
		clk_en = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		upper_byte_select = 1'b0;
		vin = 12'h000;
		repeat (2) @(posedge clock);
		#10 rstn = 1'b1;
		no_select_read();
		frozen_start();
		convert(12'ha5c, 12'h000, 1'b0);
		byte_read(12'ha5c);
		convert(12'h3f1, 12'ha5c, 1'b1);
		convert(12'hfff, 12'h3f1, 1'b0);
		convert(12'h001, 12'hfff, 1'b0);
		byte_read(12'h001);
		give_verdict();
	end
endmodule
